// file: include/hub_desc_pkg.sv
// Functional notes
// - Hub descriptor byte 6 reports controller current, mA.
// - Supply mode 0 bus current, 1 self current.
// - Current covers hub only, not attached peripherals.
// - Byte 8 is constant FFh power mask.
// - Maker, product, serial texts, 60 bytes each.
// - String zero: 04h, 03h, language code.
// - Maker string: length plus two, 03h, text.
// - Product string: length plus two, 03h, text.
// - Serial string: length plus two, 03h, text.
// - Port count is three minus disabled ports.
// - Hub descriptor answered for type 29h or 00h.
package hub_desc_pkg;
	typedef logic [7:0] octet_t;

	// ------------------------------------------------------------------
	// Register offsets on the configuration port
	// ------------------------------------------------------------------
	localparam octet_t OFS_CONFIG_ONE   = 8'h06;
	localparam octet_t OFS_CURRENT_BUS  = 8'h0F;
	localparam octet_t OFS_CURRENT_SELF = 8'h10;
	localparam octet_t OFS_DEVICE_MASK  = 8'h11;
	localparam octet_t OFS_LANG_UPPER   = 8'h12;
	localparam octet_t OFS_LANG_LOWER   = 8'h13;
	localparam octet_t OFS_MAKER_LEN    = 8'h14;
	localparam octet_t OFS_PRODUCT_LEN  = 8'h15;
	localparam octet_t OFS_SERIAL_LEN   = 8'h16;
	localparam octet_t OFS_DIS_BUS      = 8'h17;
	localparam octet_t OFS_DIS_SELF     = 8'h18;
	localparam octet_t OFS_HUB_CHAR     = 8'h19;
	localparam octet_t OFS_POWER_ON     = 8'h1A;
	localparam octet_t OFS_TEXT_BASE    = 8'h40;
	localparam int     TEXT_SLOT_LSB    = 6;
	localparam int     TEXT_BYTES       = 60;
	localparam int     TEXT_SLOTS       = 3;
	localparam int     SUPPLY_MODE_BIT  = 7;
	localparam int     PORT_FIRST       = 1;
	localparam int     PORT_TOTAL       = 3;
	localparam octet_t READ_UNMAPPED    = 8'h00;

	// ------------------------------------------------------------------
	// Descriptor constants and byte positions
	// ------------------------------------------------------------------
	localparam octet_t HUB_DESC_LEN     = 8'h09;
	localparam octet_t HUB_TYPE         = 8'h29;
	localparam octet_t HUB_TYPE_LEGACY  = 8'h00;
	localparam octet_t STRING_TYPE      = 8'h03;
	localparam octet_t LANG_DESC_LEN    = 8'h04;
	localparam octet_t PWR_MASK_ALL     = 8'hFF;
	localparam octet_t STR_HDR          = 8'h02;
	localparam octet_t CHAR_HIGH        = 8'h00;
	localparam octet_t STR_INDEX_LAST   = 8'h03;
	localparam octet_t POS_LEN          = 8'h00;
	localparam octet_t POS_TYPE         = 8'h01;
	localparam octet_t POS_PORTS        = 8'h02;
	localparam octet_t POS_CHAR_LO      = 8'h03;
	localparam octet_t POS_CHAR_HI      = 8'h04;
	localparam octet_t POS_POWER_ON     = 8'h05;
	localparam octet_t POS_CURRENT      = 8'h06;
	localparam octet_t POS_REMOVABLE    = 8'h07;
	localparam octet_t POS_PWR_MASK     = 8'h08;

	typedef enum logic [2:0] {
		KIND_HUB, KIND_LANG, KIND_MAKER, KIND_PRODUCT, KIND_SERIAL
	} desc_kind_t;
	typedef enum logic {PH_IDLE, PH_SEND} phase_t;

	typedef struct packed {
		octet_t        desc_type;
		octet_t        desc_index;
		logic [15:0]   length;
	} req_t;

	typedef struct packed {
		logic   wr;
		logic   rd;
		octet_t addr;
		octet_t wdata;
	} cfg_t;

	typedef struct packed {
		phase_t     phase;
		desc_kind_t kind;
		octet_t     pos;
		octet_t     count;
		octet_t     tx_data;
		logic       empty;
		logic       stall;
		octet_t     cfg_rdata;
		octet_t     config_one;
		octet_t     current_bus;
		octet_t     current_self;
		octet_t     device_mask;
		octet_t     lang_upper;
		octet_t     lang_lower;
		octet_t     maker_len;
		octet_t     product_len;
		octet_t     serial_len;
		octet_t     dis_bus;
		octet_t     dis_self;
		octet_t     hub_char;
		octet_t     power_on;
		octet_t [TEXT_SLOTS-1:0][TEXT_BYTES-1:0] text;
	} state_t;
endpackage : hub_desc_pkg

// file: rtl/hub_descriptor_responder.sv
`timescale 1ns/100ps
module hub_descriptor_responder (
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire hub_desc_pkg::cfg_t   cfg,
	output      hub_desc_pkg::octet_t cfg_rdata,
	input  wire logic                 req_valid,
	input  wire hub_desc_pkg::req_t   req,
	output      logic                 req_ready,
	output      logic                 req_stall,
	output      logic                 resp_empty,
	output      logic                 tx_valid,
	output      hub_desc_pkg::octet_t tx_data,
	output      logic                 tx_last,
	input  wire logic                 tx_ready
);
	import hub_desc_pkg::*;

	state_t st;
	state_t next_st;

	// ------------------------------------------------------------------
	// Descriptor content
	// ------------------------------------------------------------------

	// Stored text length of one string slot
	function automatic octet_t text_len(state_t s, desc_kind_t k);
		case (k)
			KIND_MAKER:   text_len = s.maker_len;
			KIND_PRODUCT: text_len = s.product_len;
			KIND_SERIAL:  text_len = s.serial_len;
			default:      text_len = '0;
		endcase
	endfunction : text_len

	// Whole length of a descriptor
	function automatic octet_t desc_len(state_t s, desc_kind_t k);
		case (k)
			KIND_HUB:  desc_len = HUB_DESC_LEN;
			KIND_LANG: desc_len = LANG_DESC_LEN;
			default:   desc_len = text_len(s, k) + STR_HDR;
		endcase
	endfunction : desc_len

	// Ports left after removing the disabled set of the current mode
	function automatic octet_t port_count(state_t s);
		octet_t dis;
		octet_t n;
		dis = s.config_one[SUPPLY_MODE_BIT] ? s.dis_self : s.dis_bus;
		n = octet_t'(PORT_TOTAL);
		for (int i = PORT_FIRST; i <= PORT_TOTAL; i++) begin
			if (dis[i])
				n = n - 8'h01;
		end
		port_count = n;
	endfunction : port_count

	// One byte of a descriptor at a position
	function automatic octet_t byte_at(state_t s, desc_kind_t k, octet_t p);
		octet_t b;
		octet_t idx;
		int     slot;
		b = '0;
		idx = p - STR_HDR;
		slot = int'(k) - int'(KIND_MAKER);
		case (k)
			KIND_HUB: begin
				case (p)
					POS_LEN:       b = HUB_DESC_LEN;
					POS_TYPE:      b = HUB_TYPE;
					POS_PORTS:     b = port_count(s);
					POS_CHAR_LO:   b = s.hub_char;
					POS_CHAR_HI:   b = CHAR_HIGH;
					POS_POWER_ON:  b = s.power_on;
					// Hub-only draw from upstream power, per mode
					POS_CURRENT:   b = s.config_one[SUPPLY_MODE_BIT] ?
						s.current_self : s.current_bus;
					POS_REMOVABLE: b = s.device_mask;
					POS_PWR_MASK:  b = PWR_MASK_ALL;
					default:       b = '0;
				endcase
			end
			KIND_LANG: begin
				case (p)
					POS_LEN:  b = LANG_DESC_LEN;
					POS_TYPE: b = STRING_TYPE;
					POS_PORTS:   b = s.lang_lower;
					POS_CHAR_LO: b = s.lang_upper;
					default:  b = '0;
				endcase
			end
			default: begin
				if (p == POS_LEN)
					b = text_len(s, k) + STR_HDR;
				else if (p == POS_TYPE)
					b = STRING_TYPE;
				else if (int'(idx) < TEXT_BYTES)
					b = s.text[slot][idx];
			end
		endcase
		byte_at = b;
	endfunction : byte_at

	// Configuration read mux, unmapped reads give zero
	function automatic octet_t reg_read(state_t s, octet_t a);
		case (a)
			OFS_CONFIG_ONE:   reg_read = s.config_one;
			OFS_CURRENT_BUS:  reg_read = s.current_bus;
			OFS_CURRENT_SELF: reg_read = s.current_self;
			OFS_DEVICE_MASK:  reg_read = s.device_mask;
			OFS_LANG_UPPER:   reg_read = s.lang_upper;
			OFS_LANG_LOWER:   reg_read = s.lang_lower;
			OFS_MAKER_LEN:    reg_read = s.maker_len;
			OFS_PRODUCT_LEN:  reg_read = s.product_len;
			OFS_SERIAL_LEN:   reg_read = s.serial_len;
			OFS_DIS_BUS:      reg_read = s.dis_bus;
			OFS_DIS_SELF:     reg_read = s.dis_self;
			OFS_HUB_CHAR:     reg_read = s.hub_char;
			OFS_POWER_ON:     reg_read = s.power_on;
			default: begin
				if (a >= OFS_TEXT_BASE &&
				    int'(a[TEXT_SLOT_LSB-1:0]) < TEXT_BYTES)
					reg_read = s.text[int'(a[7:TEXT_SLOT_LSB]) - 1]
						[a[TEXT_SLOT_LSB-1:0]];
				else
					reg_read = READ_UNMAPPED;
			end
		endcase
	endfunction : reg_read

	// Lengths beyond the text store are clamped
	function automatic octet_t clamp_len(octet_t v);
		clamp_len = (int'(v) > TEXT_BYTES) ? octet_t'(TEXT_BYTES) : v;
	endfunction : clamp_len

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		octet_t     full;
		octet_t     cnt;
		desc_kind_t k;
		logic       ok;
		next_st = st;
		full = '0;
		cnt = '0;
		k = KIND_HUB;
		ok = 1'b0;
		next_st.empty = 1'b0;
		next_st.stall = 1'b0;
		// Configuration writes
		if (cfg.wr) begin
			case (cfg.addr)
				OFS_CONFIG_ONE:   next_st.config_one = cfg.wdata;
				OFS_CURRENT_BUS:  next_st.current_bus = cfg.wdata;
				OFS_CURRENT_SELF: next_st.current_self = cfg.wdata;
				OFS_DEVICE_MASK:  next_st.device_mask = cfg.wdata;
				OFS_LANG_UPPER:   next_st.lang_upper = cfg.wdata;
				OFS_LANG_LOWER:   next_st.lang_lower = cfg.wdata;
				OFS_MAKER_LEN:    next_st.maker_len = clamp_len(cfg.wdata);
				OFS_PRODUCT_LEN:  next_st.product_len = clamp_len(cfg.wdata);
				OFS_SERIAL_LEN:   next_st.serial_len = clamp_len(cfg.wdata);
				OFS_DIS_BUS:      next_st.dis_bus = cfg.wdata;
				OFS_DIS_SELF:     next_st.dis_self = cfg.wdata;
				OFS_HUB_CHAR:     next_st.hub_char = cfg.wdata;
				OFS_POWER_ON:     next_st.power_on = cfg.wdata;
				default: begin
					if (cfg.addr >= OFS_TEXT_BASE &&
					    int'(cfg.addr[TEXT_SLOT_LSB-1:0]) < TEXT_BYTES)
						next_st.text[int'(cfg.addr[7:TEXT_SLOT_LSB]) - 1]
							[cfg.addr[TEXT_SLOT_LSB-1:0]] = cfg.wdata;
				end
			endcase
		end
		// Registered read data
		if (cfg.rd)
			next_st.cfg_rdata = reg_read(st, cfg.addr);
		// Request decode and byte streaming
		case (st.phase)
			PH_IDLE: begin
				if (req_valid) begin
					if (req.desc_type == HUB_TYPE ||
					    req.desc_type == HUB_TYPE_LEGACY) begin
						k = KIND_HUB;
						ok = 1'b1;
					end else if (req.desc_type == STRING_TYPE &&
					             req.desc_index <= STR_INDEX_LAST) begin
						k = desc_kind_t'(req.desc_index[2:0] + 3'h1);
						ok = 1'b1;
					end
					full = desc_len(st, k);
					cnt = (req.length < {8'h00, full}) ?
						req.length[7:0] : full;
					if (!ok)
						next_st.stall = 1'b1;
					else if (cnt == '0)
						next_st.empty = 1'b1;
					else begin
						next_st.phase = PH_SEND;
						next_st.kind = k;
						next_st.pos = '0;
						next_st.count = cnt;
						next_st.tx_data = byte_at(st, k, '0);
					end
				end
			end
			PH_SEND: begin
				if (tx_ready) begin
					if (st.pos + 8'h01 == st.count)
						next_st.phase = PH_IDLE;
					else begin
						next_st.pos = st.pos + 8'h01;
						next_st.tx_data = byte_at(st, st.kind,
							st.pos + 8'h01);
					end
				end
			end
			default: next_st.phase = PH_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs
	assign req_ready  = (st.phase == PH_IDLE);
	assign tx_valid   = (st.phase == PH_SEND);
	assign tx_last    = tx_valid && (st.pos + 8'h01 == st.count);
	assign tx_data    = st.tx_data;
	assign req_stall  = st.stall;
	assign resp_empty = st.empty;
	assign cfg_rdata  = st.cfg_rdata;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_hub_current: assert property (
		tx_valid && st.kind == KIND_HUB && st.pos == POS_CURRENT |->
		tx_data == (st.config_one[SUPPLY_MODE_BIT] ?
			st.current_self : st.current_bus))
		else $error("hub current byte wrong");
	a_removable_mask: assert property (
		tx_valid && st.kind == KIND_HUB && st.pos == POS_REMOVABLE |->
		tx_data == st.device_mask)
		else $error("device mask byte wrong");
	a_power_mask: assert property (
		tx_valid && st.kind == KIND_HUB && st.pos == POS_PWR_MASK |->
		tx_data == PWR_MASK_ALL)
		else $error("power mask byte wrong");
	a_lang_header: assert property (
		req_valid && req_ready && req.desc_type == STRING_TYPE &&
		req.desc_index == '0 && req.length != '0 |=>
		tx_valid && tx_data == LANG_DESC_LEN)
		else $error("language descriptor length wrong");
	a_string_length: assert property (
		tx_valid && st.kind > KIND_LANG && st.pos == POS_LEN |->
		tx_data == text_len(st, st.kind) + STR_HDR)
		else $error("string length byte wrong");
	a_string_type: assert property (
		tx_valid && st.kind != KIND_HUB && tx_ready &&
		st.pos == POS_LEN && !tx_last |=> tx_data == STRING_TYPE)
		else $error("string type byte wrong");
	a_text_byte: assert property (
		tx_valid && st.kind > KIND_LANG && st.pos >= STR_HDR |->
		tx_data == st.text[int'(st.kind) - int'(KIND_MAKER)]
			[st.pos - STR_HDR])
		else $error("string text byte wrong");
	a_port_count: assert property (
		tx_valid && st.kind == KIND_HUB && st.pos == POS_PORTS |->
		tx_data <= octet_t'(PORT_TOTAL) && tx_data == port_count(st))
		else $error("port count byte wrong");
	a_hub_accept: assert property (
		req_valid && req_ready && (req.desc_type == HUB_TYPE ||
		req.desc_type == HUB_TYPE_LEGACY) |=>
		(tx_valid && tx_data == HUB_DESC_LEN) || resp_empty)
		else $error("hub descriptor request not answered");
	a_short_request: assert property (
		req_valid && req_ready && req.length != '0 &&
		req.length < {8'h00, HUB_DESC_LEN} &&
		req.desc_type == HUB_TYPE |=>
		st.count == $past(req.length[7:0]))
		else $error("short request length not honoured");
	a_last_ends: assert property (
		tx_valid && tx_ready && tx_last |=> !tx_valid && req_ready)
		else $error("stream did not end after last byte");

	c_hub_full: cover property (
		tx_valid && tx_ready && tx_last && st.kind == KIND_HUB &&
		st.pos == POS_PWR_MASK);
	c_string_full: cover property (
		tx_valid && tx_ready && tx_last && st.kind == KIND_SERIAL);
	c_stall: cover property (req_stall);
	c_lang_trunc: cover property (
		tx_last && st.kind == KIND_LANG && st.pos == POS_TYPE);
endmodule : hub_descriptor_responder

// file: dv/host_sink.sv
`timescale 1ns/100ps
module host_sink (
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic tx_valid,
	input  wire logic slow,
	output      logic tx_ready
);
	// --------------------------------------------------------------
	// Byte acceptance on the host side
	// --------------------------------------------------------------
	// Prompt mode takes every byte; slow mode stalls at random
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= !slow || !tx_valid || 1'($urandom_range(1, 0));
		end
	end
endmodule : host_sink

// file: dv/hub_descriptor_responder_bench.sv
`timescale 1ns/100ps
module hub_descriptor_responder_bench;
	import hub_desc_pkg::*;

	// --------------------------------------------------------------
	// Signals and reference state
	// --------------------------------------------------------------
	logic        sys_clk;
	logic        rstn;
	cfg_t        cfg;
	octet_t      cfg_rdata;
	logic        req_valid;
	req_t        req;
	logic        req_ready;
	logic        req_stall;
	logic        resp_empty;
	logic        tx_valid;
	octet_t      tx_data;
	logic        tx_last;
	logic        tx_ready;
	logic        slow;
	logic [9:0]  got;
	logic [9:0]  q[$];
	octet_t      d[$];
	octet_t      v[10];
	octet_t      tx[4][TEXT_BYTES];
	int          tl[4];
	int          err_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	octet_t      ofs[10] = '{OFS_CONFIG_ONE, OFS_CURRENT_BUS, OFS_CURRENT_SELF,
		OFS_DEVICE_MASK, OFS_LANG_UPPER, OFS_LANG_LOWER, OFS_DIS_BUS,
		OFS_DIS_SELF, OFS_HUB_CHAR, OFS_POWER_ON};

	hub_descriptor_responder dut (.sys_clk(sys_clk), .rstn(rstn), .cfg(cfg),
		.cfg_rdata(cfg_rdata), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .req_stall(req_stall),
		.resp_empty(resp_empty), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready));
	host_sink host (.sys_clk(sys_clk), .rstn(rstn), .tx_valid(tx_valid),
		.slow(slow), .tx_ready(tx_ready));

	always #5 sys_clk = !sys_clk;

	// --------------------------------------------------------------
	// Compare, configuration access, expected descriptors
	// --------------------------------------------------------------
	task automatic chk(logic [9:0] g, logic [9:0] e);
		num_checks++;
		if (g !== e) begin
			$display("mismatch at %0t got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask : chk

	task automatic wr(octet_t a, octet_t x);
		@(posedge sys_clk);
		cfg <= '{1'b1, 1'b0, a, x};
		@(posedge sys_clk);
		cfg <= '0;
	endtask : wr

	task automatic rd(octet_t a, octet_t e);
		@(posedge sys_clk);
		cfg <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		cfg <= '0;
		@(negedge sys_clk);
		chk({2'b00, cfg_rdata}, {2'b00, e});
	endtask : rd

	function automatic void build(octet_t t, octet_t ix);
		octet_t ds;
		d = {};
		ds = v[0][7] ? v[7] : v[6];
		if (t != STRING_TYPE)
			d = {HUB_DESC_LEN, HUB_TYPE, octet_t'(PORT_TOTAL - $countones(ds[3:1])),
				v[8], CHAR_HIGH, v[9], v[0][7] ? v[2] : v[1], v[3], PWR_MASK_ALL};
		else if (ix == 0)
			d = {LANG_DESC_LEN, STRING_TYPE, v[5], v[4]};
		else if (ix <= STR_INDEX_LAST) begin
			d = {octet_t'(tl[ix] + 2), STRING_TYPE};
			for (int i = 0; i < tl[ix]; i++) d.push_back(tx[ix][i]);
		end
	endfunction : build

	// Random settings for one supply mode; maker text 60 bytes, serial text empty in bus mode
	task automatic setup(logic m);
		foreach (v[i]) begin
			v[i] = (i == 0) ? {m, 7'h00} : octet_t'($urandom);
			wr(ofs[i], v[i]);
		end
		for (int s = 1; s < 4; s++) begin
			tl[s] = s == 1 ? TEXT_BYTES : (s == 3 && !m) ? 0 : $urandom_range(59, 1);
			wr(octet_t'(OFS_MAKER_LEN + s - 1), octet_t'(tl[s]));
			for (int i = 0; i < tl[s]; i++) begin
				tx[s][i] = octet_t'($urandom);
				wr(octet_t'(s * OFS_TEXT_BASE + i), tx[s][i]);
			end
		end
		rd(OFS_CURRENT_SELF, v[2]);
	endtask : setup

	// Notes the expected answer, then issues the request
	task automatic ask(octet_t t, octet_t ix, logic [15:0] n);
		int k;
		build(t, ix);
		k = n < d.size() ? n : d.size();
		if (!(t == HUB_TYPE || t == HUB_TYPE_LEGACY ||
			t == STRING_TYPE && ix <= STR_INDEX_LAST)) q.push_back(10'h200);
		else if (k == 0) q.push_back(10'h300);
		else for (int i = 0; i < k; i++) q.push_back({1'b0, i == k - 1, d[i]});
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= '{t, ix, n};
		@(posedge sys_clk);
		req_valid <= 1'b0;
		do @(negedge sys_clk); while (q.size() != 0 || req_ready !== 1'b1);
	endtask : ask

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up

	// --------------------------------------------------------------
	// Output watcher and hang guard
	// --------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rstn === 1'b1 && (tx_valid === 1'b1 && tx_ready === 1'b1 ||
			req_stall === 1'b1 || resp_empty === 1'b1)) begin
			got = req_stall ? 10'h200 : resp_empty ? 10'h300 :
				{1'b0, tx_last, tx_data};
			if (q.size() == 0) chk(got, 10'h3FF);
			else chk(got, q.pop_front());
		end
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			wrap_up();
		end
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		cfg = '0;
		req_valid = 1'b0;
		req = '0;
		slow = 1'b0;
		void'($urandom(21502));
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(OFS_CURRENT_BUS, 8'h00);
		rd(OFS_CONFIG_ONE, 8'h00);
		rd(8'h20, READ_UNMAPPED);
		rd(8'h7C, READ_UNMAPPED);
		for (int m = 0; m < 2; m++) begin
			slow <= 1'(m);
			setup(1'(m));
			ask(HUB_TYPE, 8'h00, 16'h0009);
			ask(HUB_TYPE_LEGACY, 8'h00, 16'h0100);
			ask(HUB_TYPE, 8'h00, 16'($urandom_range(8, 1)));
			ask(HUB_TYPE, 8'h00, 16'h0000);
			for (int s = 0; s < 4; s++)
				ask(STRING_TYPE, octet_t'(s), 16'h00FF);
			ask(STRING_TYPE, 8'h02, 16'h0005);
			ask(STRING_TYPE, 8'h00, 16'h0002);
			ask(STRING_TYPE, 8'h04, 16'h0002);
			ask(8'h05, 8'h00, 16'h0009);
		end
		// Mid-run reset clears every configuration register
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		v = '{default: 8'h00};
		tl = '{default: 0};
		ask(HUB_TYPE, 8'h00, 16'h0009);
		rd(OFS_CURRENT_SELF, 8'h00);
		wrap_up();
	end
endmodule : hub_descriptor_responder_bench
